// File: core/irq_prio_ctrl.sv
// Purpose: Interrupt priority routing, external/timer0/port-B sources
// Assumes: AXI4-Lite register access, sources on clk_sys except pins
// Notes:   Requests and wake are registered, one cycle after cause
// ==========================================================
// What this block does
// - Priority bit one routes high, zero low
// - First priority byte: eight bits, reset one
// - Second priority byte bit four reads zero
// - Second priority byte other bits reset one
// - Third priority byte: eight bits, reset one
// - Reset-control top bit enables two levels
// - Six reset cause flags, bit six zero
// - External pins edge-triggered, selectable edge
// - Edge sets flag regardless of enable
// - Enabled external flag wakes from sleep
// - Vector after wake only with global enable
// - External 1,2,3 priority bit locations
// - External input zero always high priority
// - Timer0 8-bit wrap sets its flag
// - Timer0 16-bit flags only full wrap
// - Timer0 enable and priority bit locations
// - Port-B upper pin change sets flag
// - Taking interrupt pushes PC, saves context
// - Priority bits act only with levels on
// - Single level needs peripheral gate
`timescale 1ns/1ps
`default_nettype none
module irq_prio_ctrl
   import irq_prio_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic srst, // Synchronous reset, high
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [3:0] ext_pin, // External interrupt pins 3..0
   input wire logic [3:0] portb_pin, // Port-B pins 7..4
   input wire logic [15:0] timer0_count, // Timer0 high:low count
   input wire logic [23:0] periph_flag, // Peripheral flags
   input wire logic [23:0] periph_enable, // Peripheral enables
   input wire logic [5:0] cause_clear, // Reset cause clear pulses
   input wire logic sleep_mode, // Core in power-managed mode
   input wire logic irq_taken, // Core takes an interrupt
   input wire logic ret_pop, // Core returns from interrupt
   input wire logic [PC_W-1:0] pc_in, // Return address to save
   input wire logic [7:0] working_in, // Working register now
   input wire logic [7:0] status_in, // Status register now
   input wire logic [7:0] bank_in, // Bank select register now
   output logic irq_high, // High priority request
   output logic irq_low, // Low priority request
   output logic wake_req, // Wake the core
   output logic [PC_W-1:0] ret_pc, // Top of return stack
   output logic [7:0] fast_working, // Saved working register
   output logic [7:0] fast_status, // Saved status register
   output logic [7:0] fast_bank // Saved bank select register
);
   // ==========================================================
   // Registers and wires
   logic [7:0] prio1_reg, prio2_reg, prio3_reg, rstctl_reg;
   logic [7:0] ctla_reg, ctlb_reg, ctlc_reg;
   logic [7:0] ctla_next, ctlc_next;
   logic [7:0] pin_s1_reg, pin_s2_reg, pin_last_reg;
   logic [3:0] ext_edge, ext_flag, ext_en, wake_mask_reg;
   logic [15:0] t0_prev_reg;
   logic t0_wrap, pb_change, sleep_d_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic w_lane_reg, aw_have_reg, w_have_reg, wr_do;
   logic [4:0] sp_reg;
   logic [23:0] per_req, per_pri;
   logic core_hi, core_lo, per_hi, per_lo, prio_on, global_irq_enable, gate;

   // Same word decode for reads and writes
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction : hit

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, OFF_PRIO1) || hit(a, OFF_PRIO2) ||
               hit(a, OFF_PRIO3) || hit(a, OFF_RSTCTL) ||
               hit(a, OFF_CTLA) || hit(a, OFF_CTLB) ||
               hit(a, OFF_CTLC) || hit(a, OFF_STACK);
   endfunction : mapped

   function automatic logic wr_to(input logic [7:0] off);
      wr_to = wr_do && w_lane_reg && hit(aw_addr_reg, off);
   endfunction : wr_to

   // ==========================================================
   // AXI4-Lite write channel: address and data in either order
   assign wr_do = aw_have_reg && w_have_reg;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_axi_awready <= 1'b0;
         aw_have_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_have_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (wr_do) begin
         aw_have_reg <= 1'b0;
      end else if (!aw_have_reg && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   // Only the low byte lane carries register data
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_axi_wready <= 1'b0;
         w_have_reg <= 1'b0;
         w_data_reg <= '0;
         w_lane_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_have_reg <= 1'b1;
         w_data_reg <= s_axi_wdata[7:0];
         w_lane_reg <= s_axi_wstrb[0];
      end else if (wr_do) begin
         w_have_reg <= 1'b0;
      end else if (!w_have_reg && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Response one cycle after both halves are held
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // AXI4-Lite read channel; reads have no side effects
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         s_axi_rdata <= '0;
         if (hit(s_axi_araddr, OFF_PRIO1)) s_axi_rdata[7:0] <= prio1_reg;
         if (hit(s_axi_araddr, OFF_PRIO2)) s_axi_rdata[7:0] <= prio2_reg;
         if (hit(s_axi_araddr, OFF_PRIO3)) s_axi_rdata[7:0] <= prio3_reg;
         if (hit(s_axi_araddr, OFF_RSTCTL)) s_axi_rdata[7:0] <= rstctl_reg;
         if (hit(s_axi_araddr, OFF_CTLA)) s_axi_rdata[7:0] <= ctla_reg;
         if (hit(s_axi_araddr, OFF_CTLB)) s_axi_rdata[7:0] <= ctlb_reg;
         if (hit(s_axi_araddr, OFF_CTLC)) s_axi_rdata[7:0] <= ctlc_reg;
         if (hit(s_axi_araddr, OFF_STACK)) s_axi_rdata[4:0] <= sp_reg;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================
   // Priority bytes; bit 4 of the second never stores a one
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prio1_reg <= PRIO_RST;
         prio2_reg <= PRIO_RST & PRIO2_MASK;
         prio3_reg <= PRIO_RST;
      end else begin
         if (wr_to(OFF_PRIO1)) prio1_reg <= w_data_reg;
         if (wr_to(OFF_PRIO2)) prio2_reg <= w_data_reg & PRIO2_MASK;
         if (wr_to(OFF_PRIO3)) prio3_reg <= w_data_reg;
      end
   end

   // Reset control: level enable, cause flags; hardware clear wins
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rstctl_reg <= RSTCTL_RST;
      end else begin
         rstctl_reg <= (wr_to(OFF_RSTCTL) ?
                        ((w_data_reg & RSTCTL_WMASK) |
                         (rstctl_reg & ~RSTCTL_WMASK)) : rstctl_reg) &
                       ~{2'b00, cause_clear};
      end
   end

   // Edge selects, timer0 width, and timer0, ext3 and port-B priorities
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctlb_reg <= CTLB_RST;
      end else if (wr_to(OFF_CTLB)) begin
         ctlb_reg <= w_data_reg;
      end
   end

   // ==========================================================
   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pin_last_reg <= '0;
      end else begin
         pin_s1_reg <= {portb_pin, ext_pin};
         pin_s2_reg <= pin_s1_reg;
         pin_last_reg <= pin_s2_reg;
      end
   end

   // Per-pin edge select: one picks rising, zero falling
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_edge
         assign ext_edge[gi] = ctlb_reg[CB_EDGE+gi] ?
            (pin_s2_reg[gi] && !pin_last_reg[gi]) :
            (!pin_s2_reg[gi] && pin_last_reg[gi]);
      end
   endgenerate

   // Any mismatch on the four monitored pins
   assign pb_change = |(pin_s2_reg[7:4] ^ pin_last_reg[7:4]);

   // Timer0 wrap, width chosen by software
   assign t0_wrap = ctlb_reg[CB_WIDE] ?
      (t0_prev_reg == T0_TOP16 && timer0_count == '0) :
      (t0_prev_reg[7:0] == T0_TOP8 && timer0_count[7:0] == '0);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         t0_prev_reg <= '0;
      end else begin
         t0_prev_reg <= timer0_count;
      end
   end

   // ==========================================================
   // Flag registers: hardware set wins over a software clear
   always_comb begin
      ctla_next = wr_to(OFF_CTLA) ? w_data_reg : ctla_reg;
      ctla_next[CA_X0FL] = ctla_next[CA_X0FL] | ext_edge[0];
      ctla_next[CA_T0FL] = ctla_next[CA_T0FL] | t0_wrap;
      ctla_next[CA_PBFL] = ctla_next[CA_PBFL] | pb_change;
      ctlc_next = wr_to(OFF_CTLC) ? w_data_reg : ctlc_reg;
      ctlc_next[CC_XFL+:3] = ctlc_next[CC_XFL+:3] | ext_edge[3:1];
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctla_reg <= CTLA_RST;
         ctlc_reg <= CTLC_RST;
      end else begin
         ctla_reg <= ctla_next;
         ctlc_reg <= ctlc_next;
      end
   end

   // ==========================================================
   // Request routing
   assign ext_flag = {ctlc_reg[CC_XFL+:3], ctla_reg[CA_X0FL]};
   assign ext_en = {ctlc_reg[CC_XEN+:3], ctla_reg[CA_X0EN]};
   assign prio_on = rstctl_reg[RC_PRIO_ON];
   assign global_irq_enable = ctla_reg[CA_GIE];
   assign gate = ctla_reg[CA_GATE];
   assign per_req = periph_flag & periph_enable &
                    {8'hFF, PRIO2_MASK, 8'hFF};
   assign per_pri = {prio3_reg, prio2_reg, prio1_reg};
   assign per_hi = |(per_req & per_pri);
   assign per_lo = |(per_req & ~per_pri);

   // Input zero has no priority bit and always lands high
   always_comb begin
      core_hi = (ext_flag[0] && ext_en[0]) ||
         (ext_flag[1] && ext_en[1] && ctlc_reg[CC_X1P]) ||
         (ext_flag[2] && ext_en[2] && ctlc_reg[CC_X2P]) ||
         (ext_flag[3] && ext_en[3] && ctlb_reg[CB_X3P]) ||
         (ctla_reg[CA_T0FL] && ctla_reg[CA_T0EN] &&
          ctlb_reg[CB_T0P]) ||
         (ctla_reg[CA_PBFL] && ctla_reg[CA_PBEN] &&
          ctlb_reg[CB_PBP]);
      core_lo = (ext_flag[1] && ext_en[1] && !ctlc_reg[CC_X1P]) ||
         (ext_flag[2] && ext_en[2] && !ctlc_reg[CC_X2P]) ||
         (ext_flag[3] && ext_en[3] && !ctlb_reg[CB_X3P]) ||
         (ctla_reg[CA_T0FL] && ctla_reg[CA_T0EN] &&
          !ctlb_reg[CB_T0P]) ||
         (ctla_reg[CA_PBFL] && ctla_reg[CA_PBEN] &&
          !ctlb_reg[CB_PBP]);
   end

   // With levels off, everything goes high; peripherals need the gate
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq_high <= 1'b0;
         irq_low <= 1'b0;
      end else if (prio_on) begin
         irq_high <= global_irq_enable && (core_hi || per_hi);
         irq_low <= global_irq_enable && gate && (core_lo || per_lo);
      end else begin
         irq_high <= global_irq_enable && (core_hi || core_lo ||
                     (gate && (per_hi || per_lo)));
         irq_low <= 1'b0;
      end
   end

   // ==========================================================
   // Wake: only sources enabled before sleep began may wake.
   // Vectoring still depends on irq_high/irq_low, which need gie.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sleep_d_reg <= 1'b0;
         wake_mask_reg <= '0;
         wake_req <= 1'b0;
      end else begin
         sleep_d_reg <= sleep_mode;
         if (sleep_mode && !sleep_d_reg) begin
            wake_mask_reg <= ext_en;
         end
         wake_req <= sleep_mode && sleep_d_reg &&
                     |(ext_flag & wake_mask_reg);
      end
   end

   // ==========================================================
   // Context save; a push beyond depth is dropped
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sp_reg <= '0;
         fast_working <= '0;
         fast_status <= '0;
         fast_bank <= '0;
      end else if (irq_taken) begin
         fast_working <= working_in;
         fast_status <= status_in;
         fast_bank <= bank_in;
         if (sp_reg != 5'(STACK_DEPTH)) sp_reg <= sp_reg + 5'h01;
      end else if (ret_pop && sp_reg != '0) begin
         sp_reg <= sp_reg - 5'h01;
      end
   end

   ret_stack_mem u_stack (
      .clk_sys(clk_sys),
      .we(irq_taken && sp_reg != 5'(STACK_DEPTH)),
      .waddr(sp_reg[STACK_AW-1:0]),
      .wdata(pc_in),
      .raddr(4'(sp_reg - 5'h01)),
      .rdata(ret_pc)
   );

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence s_write_ready;
      wr_do;
   endsequence
   sequence s_response;
      s_axi_bvalid [*1];
   endsequence
   sequence s_take;
      irq_taken && sp_reg != 5'(STACK_DEPTH);
   endsequence

   chk_write_answer: assert property (
      s_write_ready |=> s_response)
      else $error("write response not one cycle after write");
   chk_prio2_hole: assert property (
      !prio2_reg[4])
      else $error("unimplemented priority bit reads one");
   chk_ext_flag_set: assert property (
      ext_edge[1] |=> ext_flag[1])
      else $error("edge did not set external flag");
   chk_t0_narrow: assert property (
      !ctlb_reg[CB_WIDE] && t0_prev_reg[7:0] == 8'hFF &&
      timer0_count[7:0] == 8'h00 |=> ctla_reg[CA_T0FL])
      else $error("8-bit wrap missed");
   chk_t0_wide_hold: assert property (
      ctlb_reg[CB_WIDE] && timer0_count[15:8] != 8'h00 &&
      !ctla_reg[CA_T0FL] && !wr_to(OFF_CTLA) |=> !ctla_reg[CA_T0FL])
      else $error("16-bit flag set without full wrap");
   chk_portb_flag: assert property (
      pin_s2_reg[7:4] != pin_last_reg[7:4] |=> ctla_reg[CA_PBFL])
      else $error("port-B change missed");
   chk_zero_high: assert property (
      global_irq_enable && ext_flag[0] && ext_en[0] |=> irq_high && !$past(srst))
      else $error("input zero not routed high");
   chk_single_level: assert property (
      !prio_on |=> !irq_low)
      else $error("low request with levels off");
   chk_gate_needed: assert property (
      !prio_on && !gate && !core_hi && !core_lo |=> !irq_high)
      else $error("peripheral raised request without gate");
   chk_fast_save: assert property (
      s_take |=> fast_working == $past(working_in) &&
      sp_reg == $past(sp_reg) + 5'h01 ##1 ret_pc == $past(pc_in, 2))
      else $error("context not saved on interrupt");
endmodule : irq_prio_ctrl
`default_nettype wire

// File: core/irq_prio_pkg.sv
// Purpose: Shared constants for the interrupt priority and source block
// Assumes: 8-bit registers, each on an aligned word of an AXI4-Lite slave
// Notes:   Field positions are bit indices inside their 8-bit register
package irq_prio_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_PRIO1 = 8'h00;
   localparam logic [7:0] OFF_PRIO2 = 8'h04;
   localparam logic [7:0] OFF_PRIO3 = 8'h08;
   localparam logic [7:0] OFF_RSTCTL = 8'h0C;
   localparam logic [7:0] OFF_CTLA = 8'h10;
   localparam logic [7:0] OFF_CTLB = 8'h14;
   localparam logic [7:0] OFF_CTLC = 8'h18;
   localparam logic [7:0] OFF_STACK = 8'h1C;
   // ==========================================================
   // Reset values and write masks
   localparam logic [7:0] PRIO_RST = 8'hFF;
   localparam logic [7:0] PRIO2_MASK = 8'hEF;
   localparam logic [7:0] RSTCTL_RST = 8'h3C;
   localparam logic [7:0] RSTCTL_WMASK = 8'hB3;
   localparam logic [7:0] CTLA_RST = 8'h00;
   localparam logic [7:0] CTLB_RST = 8'h7F;
   localparam logic [7:0] CTLC_RST = 8'hC0;
   // ==========================================================
   // Field positions
   localparam int RC_PRIO_ON = 7;
   localparam int CA_GIE = 7;
   localparam int CA_GATE = 6;
   localparam int CA_T0EN = 5;
   localparam int CA_X0EN = 4;
   localparam int CA_PBEN = 3;
   localparam int CA_T0FL = 2;
   localparam int CA_X0FL = 1;
   localparam int CA_PBFL = 0;
   localparam int CB_WIDE = 7;
   localparam int CB_EDGE = 3;
   localparam int CB_T0P = 2;
   localparam int CB_X3P = 1;
   localparam int CB_PBP = 0;
   localparam int CC_X2P = 7;
   localparam int CC_X1P = 6;
   localparam int CC_XEN = 3;
   localparam int CC_XFL = 0;
   // ==========================================================
   // Timer-0 wrap points, stack shape, bus answers
   localparam logic [7:0] T0_TOP8 = 8'hFF;
   localparam logic [15:0] T0_TOP16 = 16'hFFFF;
   localparam int STACK_DEPTH = 16;
   localparam int STACK_AW = 4;
   localparam int PC_W = 21;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : irq_prio_pkg

// File: core/ret_stack_mem.sv
// Purpose: Return address store for taken interrupts
// Assumes: One write port, one read port, same clock
// Notes:   Read data is registered; it follows raddr one cycle later
`timescale 1ns/1ps
`default_nettype none
module ret_stack_mem
   import irq_prio_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic we, // Write strobe
   input wire logic [STACK_AW-1:0] waddr, // Write slot
   input wire logic [PC_W-1:0] wdata, // Return address in
   input wire logic [STACK_AW-1:0] raddr, // Read slot
   output logic [PC_W-1:0] rdata // Registered read data
);
   logic [PC_W-1:0] mem [STACK_DEPTH];

   // ==========================================================
   // Storage; no reset, contents only matter once pushed
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read keeps the output straight from a flop
   always_ff @(posedge clk_sys) begin
      rdata <= mem[raddr];
   end
endmodule : ret_stack_mem
`default_nettype wire

// File: bench/src_model.sv
// Purpose: Far-side model of the pin and timer0 sources
// Assumes: Pin levels and counter loads are set by the bench
// Notes:   Counter steps by one, so every wrap passes its top
`timescale 1ns/1ps
`default_nettype none
module src_model (
   input wire logic clk_sys, // System clock
   input wire logic run, // Count enable
   input wire logic ld, // Load strobe
   input wire logic [15:0] ld_val, // Load value
   input wire logic [3:0] ext_lvl, // Wanted pin levels
   output logic [3:0] ext_pin, // External pins
   output logic [15:0] timer0_count // Timer0 count
);
   // ==========================================
   // Counter and pins, moving one edge after the bench
   always_ff @(posedge clk_sys) begin
      if (ld)
         timer0_count <= ld_val;
      else if (run)
         timer0_count <= timer0_count + 16'h0001;
      ext_pin <= ext_lvl;
   end
endmodule : src_model
`default_nettype wire

// File: bench/interrupt_priority_and_sources_tb_top.sv
// Purpose: Bench for irq_prio_ctrl over its bus and source pins
// Assumes: Bench is the only bus master
// Notes:   Every wait is bounded; running out fails the run
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_and_sources_tb_top
   import irq_prio_pkg::*;
();
   logic clk_sys = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, run = 0, ld = 1, irq_taken = 0;
   logic awready, wready, bvalid, arready, rvalid, irq_high, irq_low;
   logic [7:0] awaddr = 0, araddr = 0, ctx = 0, fw, fs, fb;
   logic [31:0] wdata = 0, rdata, d;
   logic [1:0] bresp, rresp, rsp;
   logic [3:0] ext_lvl = 0, ext_pin, pb = 0;
   logic slp = 0, wk;
   logic [15:0] t0, ld_val = 16'h00FD;
   logic [23:0] pf = 0, pe = 0;
   logic [PC_W-1:0] ret_pc, pc_in = 0;
   logic [7:0] ra[4] = '{OFF_PRIO1, OFF_PRIO2, OFF_PRIO3, OFF_RSTCTL};
   logic [7:0] rv[4] = '{8'hFF, 8'hEF, 8'hFF, 8'h3C};
   int err_total = 0, tests_run = 0;
   wire logic [2:0] outs = {wk, irq_high, irq_low};
   initial forever #2 clk_sys = ~clk_sys;
   src_model src_u (.clk_sys(clk_sys), .run(run), .ld(ld),
      .ld_val(ld_val), .ext_lvl(ext_lvl), .ext_pin(ext_pin),
      .timer0_count(t0));
   irq_prio_ctrl dut_u (.clk_sys(clk_sys), .srst(srst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_pin(ext_pin),
      .portb_pin(pb), .timer0_count(t0), .periph_flag(pf),
      .periph_enable(pe), .cause_clear(6'h00), .sleep_mode(slp),
      .irq_taken(irq_taken), .ret_pop(1'b0), .pc_in(pc_in),
      .working_in(ctx), .status_in(~ctx), .bank_in(ctx ^ 8'h0F),
      .irq_high(irq_high), .irq_low(irq_low), .wake_req(wk),
      .ret_pc(ret_pc), .fast_working(fw), .fast_status(fs),
      .fast_bank(fb));
   // ==========================================
   // Verdict, compare and bus tasks
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Bready stays high until bvalid is seen, as the bus demands.
   // A local done flag ends the wait: a non-blocking update is not
   // visible in the step that made it. Starting on an edge keeps a
   // strobe from being set twice in one step.
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic done = 1'b0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            rsp = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) begin
         err_total++;
         test_done();
      end
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic done = 1'b0;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            rsp = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) begin
         err_total++;
         test_done();
      end
   endtask : rd
   // Bounded wait for one output line (0 low, 1 high, 2 wake),
   // then all three compared; only the awaited one may stand
   task automatic wirq(input int sel);
      for (int n = 0; n < 20 && outs[sel] !== 1'b1; n++)
         @(posedge clk_sys);
      if (outs[sel] !== 1'b1) begin
         err_total++;
         test_done();
      end
      #1;
      chk({29'h0, outs}, 32'h1 << sel);
   endtask : wirq
   task automatic tload(input logic [15:0] v);
      ld_val <= v;
      ld <= 1'b1;
      @(posedge clk_sys);
      ld <= 1'b0;
      run <= 1'b1;
   endtask : tload
   // ==========================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      ld <= 1'b0;
      foreach (ra[i]) begin
         rd(ra[i]);
         chk(d, {24'h0, rv[i]});
      end
      rd(8'h40);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(8'h40, 8'h5A);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(OFF_PRIO2, 8'hFF);
      chk({30'h0, rsp}, {30'h0, RESP_OKAY});
      rd(OFF_PRIO2);
      chk(d, 32'h0000_00EF);
      wr(OFF_RSTCTL, 8'hFF);
      rd(OFF_RSTCTL);
      chk(d, 32'h0000_00BF);
      $display("registers test done");
      // Ext0 enabled, ext1 flagged with its enable left off
      wr(OFF_CTLA, 8'h90);
      ext_lvl <= 4'h3;
      wirq(1'b1);
      rd(OFF_CTLA);
      chk(d, 32'h0000_0092);
      rd(OFF_CTLC);
      chk(d, 32'h0000_00C1);
      wr(OFF_CTLB, 8'h7B);
      wr(OFF_CTLA, 8'hE0);
      tload(16'h00FD);
      wirq(1'b0);
      wr(OFF_CTLB, 8'hFB);
      wr(OFF_CTLA, 8'hE0);
      tload(16'h00FD);
      repeat (8) @(posedge clk_sys);
      chk({31'h0, irq_low}, 32'h0);
      tload(16'hFFFD);
      wirq(1'b0);
      run <= 1'b0;
      $display("sources test done");
      wr(OFF_CTLA, 8'hC0);
      pf <= 24'h1;
      pe <= 24'h1;
      wirq(1'b1);
      wr(OFF_PRIO1, 8'hFE);
      wirq(1'b0);
      wr(OFF_RSTCTL, 8'h00);
      wirq(1'b1);
      // Ext0 falling edge and a port-B change while asleep, gie off
      wr(OFF_CTLB, 8'hF3);
      wr(OFF_CTLA, 8'h10);
      slp <= 1'b1;
      ext_lvl <= 4'h2;
      pb <= 4'h8;
      wirq(2);
      rd(OFF_CTLA);
      chk(d, 32'h0000_0013);
      slp <= 1'b0;
      wr(OFF_CTLA, 8'h92);
      wirq(1);
      wr(OFF_CTLA, 8'h80);
      repeat (3) @(posedge clk_sys);
      chk({30'h0, irq_high, irq_low}, 32'h0);
      $display("priority test done");
      pc_in <= 21'h1ABCD;
      ctx <= 8'h5A;
      irq_taken <= 1'b1;
      @(posedge clk_sys);
      irq_taken <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk({fw, fs, fb}, 32'h005A_A555);
      chk(ret_pc, 21'h1ABCD);
      $display("context test done");
      test_done();
   end
endmodule : interrupt_priority_and_sources_tb_top
`default_nettype wire
